// file: rtl/dacfg_pkg.sv
package dacfg_pkg;
    localparam logic [7:0] OFFS_FIRST_ADDR = 8'hA3;
    localparam logic [7:0] OFFS_SECOND_ADDR = 8'hA4;
    localparam logic [7:0] AMP_CTRL_ADDR = 8'hDC;
    localparam logic [7:0] OFFS_FIRST_RST = 8'h00;
    localparam logic [7:0] OFFS_SECOND_RST = 8'h00;
    localparam logic [7:0] AMP_CTRL_RST = 8'h00;
    localparam int AMP_EN_BIT = 7;
    localparam int GAIN_HI = 6;
    localparam int GAIN_LO = 5;
    localparam int NEG_HI = 4;
    localparam int NEG_LO = 2;
    localparam int POS_HI = 1;
    localparam int POS_LO = 0;
    localparam logic [2:0] NEG_ADC_MUX = 3'h5;
    localparam logic [2:0] NEG_AGND = 3'h6;
    localparam logic [2:0] NEG_OPEN = 3'h7;
    localparam logic [1:0] POS_ADC_MUX = 2'h0;
    localparam logic [1:0] POS_AGND = 2'h3;
    localparam logic [5:0] GAIN_X1 = 6'h01;
    localparam logic [5:0] GAIN_X8 = 6'h08;
    localparam logic [5:0] GAIN_X16 = 6'h10;
    localparam logic [5:0] GAIN_X32 = 6'h20;
    localparam logic [5:0] GAIN_RST = 6'h01;
    localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

// file: rtl/dacfg_reg8.sv
`timescale 1ns/1ps
module dacfg_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // write side
    input wire logic we_i,
    input wire logic [7:0] data_i,
    // stored value
    output logic [7:0] q_o
);
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q_o <= RESET_VALUE;
        end else if (we_i) begin
            q_o <= data_i;
        end
    end
endmodule

// file: rtl/dacfg_top.sv
`timescale 1ns/1ps
module dacfg_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // amplifier steering
    output logic amp_enable_o,
    output logic [5:0] gain_factor_o,
    output logic [2:0] neg_input_select_o,
    output logic neg_connected_o,
    output logic [1:0] pos_input_select_o,
    // offset values, signed
    output logic signed [7:0] offset_comp_first_o,
    output logic signed [7:0] offset_comp_second_o
);
    logic [7:0] ctrl_q;
    logic [7:0] ofs0_q;
    logic [7:0] ofs1_q;
    logic [7:0] rdata_next;
    logic [5:0] gain_reg;
    logic [5:0] gain_next;
    logic ctrl_wr;
    logic ofs0_wr;
    logic ofs1_wr;

    // write decode; a write to any other address is dropped
    always_comb begin
        ctrl_wr = 1'b0;
        ofs0_wr = 1'b0;
        ofs1_wr = 1'b0;
        if (wr_i && addr_i == dacfg_pkg::AMP_CTRL_ADDR) begin
            ctrl_wr = 1'b1;
        end else if (wr_i && addr_i == dacfg_pkg::OFFS_FIRST_ADDR) begin
            ofs0_wr = 1'b1;
        end else if (wr_i && addr_i == dacfg_pkg::OFFS_SECOND_ADDR) begin
            ofs1_wr = 1'b1;
        end
    end

    dacfg_reg8 #(.RESET_VALUE(dacfg_pkg::AMP_CTRL_RST)) u_ctrl (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .we_i(ctrl_wr),
        .data_i(wdata_i),
        .q_o(ctrl_q)
    );
    dacfg_reg8 #(.RESET_VALUE(dacfg_pkg::OFFS_FIRST_RST)) u_ofs0 (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .we_i(ofs0_wr),
        .data_i(wdata_i),
        .q_o(ofs0_q)
    );
    dacfg_reg8 #(.RESET_VALUE(dacfg_pkg::OFFS_SECOND_RST)) u_ofs1 (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .we_i(ofs1_wr),
        .data_i(wdata_i),
        .q_o(ofs1_q)
    );

    // read data for one cycle only; unmapped reads zero
    always_comb begin
        if (addr_i == dacfg_pkg::AMP_CTRL_ADDR) begin
            rdata_next = ctrl_q;
        end else if (addr_i == dacfg_pkg::OFFS_FIRST_ADDR) begin
            rdata_next = ofs0_q;
        end else if (addr_i == dacfg_pkg::OFFS_SECOND_ADDR) begin
            rdata_next = ofs1_q;
        end else begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= dacfg_pkg::RDATA_RST;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // decoded gain is registered so the analog side sees clean levels
    always_comb begin
        case (ctrl_q[dacfg_pkg::GAIN_HI:dacfg_pkg::GAIN_LO])
            2'h0: gain_next = dacfg_pkg::GAIN_X1;
            2'h1: gain_next = dacfg_pkg::GAIN_X8;
            2'h2: gain_next = dacfg_pkg::GAIN_X16;
            default: gain_next = dacfg_pkg::GAIN_X32;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gain_reg <= dacfg_pkg::GAIN_RST;
        end else begin
            gain_reg <= gain_next;
        end
    end

    assign gain_factor_o = gain_reg;
    assign amp_enable_o = ctrl_q[dacfg_pkg::AMP_EN_BIT];
    assign neg_input_select_o = ctrl_q[dacfg_pkg::NEG_HI:dacfg_pkg::NEG_LO];
    // open code routes nothing to the inverting input
    assign neg_connected_o = neg_input_select_o != dacfg_pkg::NEG_OPEN;
    assign pos_input_select_o = ctrl_q[dacfg_pkg::POS_HI:dacfg_pkg::POS_LO];
    assign offset_comp_first_o = ofs0_q;
    assign offset_comp_second_o = ofs1_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // named steps of a register access
    sequence ctrl_wr_s;
        wr_i && addr_i == dacfg_pkg::AMP_CTRL_ADDR;
    endsequence

    sequence ofs0_wr_s;
        wr_i && addr_i == dacfg_pkg::OFFS_FIRST_ADDR;
    endsequence

    sequence ofs1_wr_s;
        wr_i && addr_i == dacfg_pkg::OFFS_SECOND_ADDR;
    endsequence

    sequence ctrl_rd_s;
        rd_i && addr_i == dacfg_pkg::AMP_CTRL_ADDR;
    endsequence

    sequence ofs0_rd_s;
        rd_i && addr_i == dacfg_pkg::OFFS_FIRST_ADDR;
    endsequence

    sequence ofs1_rd_s;
        rd_i && addr_i == dacfg_pkg::OFFS_SECOND_ADDR;
    endsequence

    sequence other_rd_s;
        rd_i && addr_i != dacfg_pkg::AMP_CTRL_ADDR && addr_i != dacfg_pkg::OFFS_FIRST_ADDR
            && addr_i != dacfg_pkg::OFFS_SECOND_ADDR;
    endsequence

    amp_enable_a: assert property (
        ctrl_wr_s |=> amp_enable_o == $past(wdata_i[dacfg_pkg::AMP_EN_BIT]))
        else $error("amp enable does not follow write");

    ctrl_hold_a: assert property (
        !(wr_i && addr_i == dacfg_pkg::AMP_CTRL_ADDR) |=> $stable(amp_enable_o)
        && $stable(neg_input_select_o) && $stable(pos_input_select_o))
        else $error("control changed without write");

    // gain follows one cycle behind the control register
    gain_unity_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::GAIN_HI:dacfg_pkg::GAIN_LO] == 2'h0)
        |=> ##1 gain_factor_o == dacfg_pkg::GAIN_X1)
        else $error("gain x1 not decoded");

    gain_x8_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::GAIN_HI:dacfg_pkg::GAIN_LO] == 2'h1)
        |=> ##1 gain_factor_o == dacfg_pkg::GAIN_X8)
        else $error("gain x8 not decoded");

    gain_x16_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::GAIN_HI:dacfg_pkg::GAIN_LO] == 2'h2)
        |=> ##1 gain_factor_o == dacfg_pkg::GAIN_X16)
        else $error("gain x16 not decoded");

    gain_decode_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::GAIN_HI:dacfg_pkg::GAIN_LO] == 2'h3)
        |=> ##1 gain_factor_o == dacfg_pkg::GAIN_X32)
        else $error("gain x32 not decoded");

    neg_select_a: assert property (
        ctrl_wr_s
        |=> neg_input_select_o == $past(wdata_i[dacfg_pkg::NEG_HI:dacfg_pkg::NEG_LO]))
        else $error("inverting select wrong");

    neg_open_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::NEG_HI:dacfg_pkg::NEG_LO] == dacfg_pkg::NEG_OPEN)
        |=> !neg_connected_o)
        else $error("inverting input not disconnected");

    neg_routed_a: assert property (
        (ctrl_wr_s and wdata_i[dacfg_pkg::NEG_HI:dacfg_pkg::NEG_LO] != dacfg_pkg::NEG_OPEN)
        |=> neg_connected_o)
        else $error("inverting input left open");

    pos_select_a: assert property (
        ctrl_wr_s
        |=> pos_input_select_o == $past(wdata_i[dacfg_pkg::POS_HI:dacfg_pkg::POS_LO]))
        else $error("non-inverting select wrong");

    offset_first_a: assert property (
        ofs0_wr_s |=> offset_comp_first_o == $past(wdata_i))
        else $error("first offset not stored");

    offset_second_a: assert property (
        ofs1_wr_s |=> offset_comp_second_o == $past(wdata_i))
        else $error("second offset not stored");

    offset_hold_a: assert property (
        !(wr_i && addr_i == dacfg_pkg::OFFS_FIRST_ADDR) |=> $stable(offset_comp_first_o))
        else $error("first offset changed without write");

    second_hold_a: assert property (
        !(wr_i && addr_i == dacfg_pkg::OFFS_SECOND_ADDR) |=> $stable(offset_comp_second_o))
        else $error("second offset changed without write");

    // back to back write and read must return the new value
    offset_rw_a: assert property (
        ofs1_wr_s ##1 ofs1_rd_s |=> rdata_o == $past(wdata_i, 2))
        else $error("second offset readback wrong");

    ctrl_read_a: assert property (
        ctrl_rd_s |=> rdata_o == $past(ctrl_q))
        else $error("control readback wrong");

    first_read_a: assert property (
        ofs0_rd_s |=> rdata_o == $past(offset_comp_first_o))
        else $error("first offset read wrong");

    second_read_a: assert property (
        ofs1_rd_s |=> rdata_o == $past(offset_comp_second_o))
        else $error("second offset read wrong");

    other_read_a: assert property (other_rd_s |=> rdata_o == 8'h00)
        else $error("unmapped address read nonzero");

    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic amp_enable_o;
    logic [5:0] gain_factor_o;
    logic [2:0] neg_input_select_o;
    logic neg_connected_o;
    logic [1:0] pos_input_select_o;
    logic signed [7:0] offset_comp_first_o;
    logic signed [7:0] offset_comp_second_o;
    logic [5:0] gains [4] = '{6'h01, 6'h08, 6'h10, 6'h20};
    logic [7:0] c;
    int n_fail = 0;
    int samples_checked = 0;
    always #5 clock_i = ~clock_i;
    dacfg_top u_dacfg_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .amp_enable_o(amp_enable_o), .gain_factor_o(gain_factor_o),
        .neg_input_select_o(neg_input_select_o), .neg_connected_o(neg_connected_o),
        .pos_input_select_o(pos_input_select_o), .offset_comp_first_o(offset_comp_first_o),
        .offset_comp_second_o(offset_comp_second_o));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk("rdata", rdata_o, exp);
        @(negedge clock_i);
        chk("rdata_idle", rdata_o, 8'h00);
    endtask
    // write then read the same register with no gap between strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        chk("rdata_b2b", rdata_o, d);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        chk("gain", {2'h0, gain_factor_o}, 8'h01);
        chk("neg_conn", {7'h0, neg_connected_o}, 8'h01);
        rd(8'hA3, 8'h00);
        rd(8'hA4, 8'h00);
        rd(8'hDC, 8'h00);
        for (int i = 0; i < 8; i++) begin
            c = {i[0], i[1:0], i[2:0], i[1:0]};
            wr(8'hDC, c);
            // gain decode lags the register by one cycle
            @(posedge clock_i);
            @(negedge clock_i);
            chk("enable", {7'h0, amp_enable_o}, {7'h0, c[7]});
            chk("gain", {2'h0, gain_factor_o}, {2'h0, gains[c[6:5]]});
            chk("neg", {5'h0, neg_input_select_o}, {5'h0, c[4:2]});
            chk("neg_conn", {7'h0, neg_connected_o}, {7'h0, c[4:2] != 3'h7});
            chk("pos", {6'h0, pos_input_select_o}, {6'h0, c[1:0]});
            rd(8'hDC, c);
        end
        wr(8'hA3, 8'h80);
        wr(8'hA4, 8'h7F);
        wr(8'hA5, 8'h11);
        rd(8'hA3, 8'h80);
        rd(8'hA4, 8'h7F);
        rd(8'hA5, 8'h00);
        chk("first", offset_comp_first_o, 8'h80);
        chk("second", offset_comp_second_o, 8'h7F);
        wr_rd(8'hA4, 8'hC3);
        wr_rd(8'hA3, 8'h3C);
        @(posedge clock_i);
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        rd(8'hA3, 8'h00);
        rd(8'hA4, 8'h00);
        rd(8'hDC, 8'h00);
        chk("gain", {2'h0, gain_factor_o}, 8'h01);
        conclude;
    end
    // whole sequence needs about 95 cycles
    initial begin
        #20000;
        n_fail++;
        conclude;
    end
endmodule
